// >>> rtl/nst_sequencer.sv
// program, erase and blank check sequencer for flash and eeprom
//
// Summary of operation
// - flash rows take up to 64 queued words
// - consecutive word: 4 op plus 9 bus
// - row equals one single then 63 consecutive
// - sector erase lasts 4000 operation periods
// - mass erase lasts 20000 operation periods
// - blank scan upward, stop at data, setup 10
// - flash check from 11 to 65546 cycles
// - eeprom check at most 2058 cycles
// - bursts for flash only, eeprom word-wise
// - each erase counts one program/erase cycle
// - single word: 9 op plus 25 bus
// - operation clock from per-array host divider
`timescale 1ns/1ns
`include "nst_regs.svh"
module nst_sequencer #(
   parameter int ERA_OP   = `NST_ERA_OP,    // sector erase periods
   parameter int MASS_OP  = `NST_MASS_OP,   // mass erase periods
   parameter int FL_WORDS = `NST_FL_WORDS,  // flash words checked
   parameter int EE_WORDS = `NST_EE_WORDS   // eeprom words checked
) (
   input  wire logic        CLK_SYS_I,         // bus clock, 250 MHz
   input  wire logic        RST_I,             // async reset, high
   input  wire logic        OSC_TICK_I,        // oscillator period enable
   input  wire logic [7:0]  FLASH_CLK_DIV_I,   // flash_clock_divider
   input  wire logic [7:0]  EEPROM_CLK_DIV_I,  // eeprom_clock_divider
   input  wire logic        CMD_VALID_I,       // command offered
   input  wire logic [2:0]  CMD_CODE_I,        // command code
   input  wire logic        CMD_ARRAY_I,       // 0 flash, 1 eeprom
   input  wire logic        WORD_BLANK_I,      // word at SCAN_ADDR_O erased
   output logic             CMD_READY_O,       // queue slot free
   output logic             BUSY_O,            // operation running
   output logic             DONE_O,            // completion pulse
   output logic             CMD_ERR_O,         // illegal command pulse
   output logic             BLANK_FAIL_O,      // last check found data
   output logic [15:0]      SCAN_ADDR_O,       // word under blank check
   output logic             SCAN_ARRAY_O,      // array under operation
   output logic             BURST_O,           // consecutive row word
   output logic             PE_INC_O,          // program/erase cycle pulse
   output logic             PE_MASS_O          // that cycle was a mass erase
);

   // ---------------------------------------------------------------
   // state and divider
   // ---------------------------------------------------------------
   nst_pkg::nst_seq_t s_ff;                   // registered state
   nst_pkg::nst_seq_t nxt_s;                  // next state
   logic              op_tick;                // operation-clock enable
   logic              div_clr;                // restart operation period
   logic [7:0]        div_sel;                // divider of running array

   // last blank check address of an array
   function automatic logic [15:0] last_word(input logic ee);
      last_word = ee ? 16'(EE_WORDS - 1) : 16'(FL_WORDS - 1);
   endfunction

   assign div_sel = s_ff.arr ? EEPROM_CLK_DIV_I : FLASH_CLK_DIV_I;

   nst_op_clk_div #(
      .DIV_W      (8)
   ) u_div (
      .clk_i      (CLK_SYS_I),
      .rst_i      (RST_I),
      .clr_i      (div_clr),
      .osc_tick_i (OSC_TICK_I),
      .div_i      (div_sel),
      .tick_o     (op_tick)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic pop;                               // queue entry consumed
      logic chain;                             // next row word follows
      pop       = 1'b0;
      chain     = 1'b0;
      nxt_s     = s_ff;
      nxt_s.done   = 1'b0;
      nxt_s.err    = 1'b0;
      nxt_s.pe_inc = 1'b0;
      div_clr   = 1'b0;
      // row continues while a flash program waits and the row has room
      chain = s_ff.q_valid && s_ff.q_cmd == `NST_CMD_PROG && !s_ff.q_arr
              && !s_ff.arr && s_ff.cmd == `NST_CMD_PROG
              && s_ff.row_cnt < 6'(`NST_ROW_WORDS - 1);
      unique case (s_ff.st)
         nst_pkg::NST_IDLE: begin
            if (s_ff.q_valid) begin            // start the queued command
               pop       = 1'b1;
               div_clr   = 1'b1;
               nxt_s.cmd = s_ff.q_cmd;
               nxt_s.arr = s_ff.q_arr;
               nxt_s.burst   = 1'b0;
               nxt_s.row_cnt = '0;
               nxt_s.addr    = '0;
               case (s_ff.q_cmd)
                  `NST_CMD_PROG: begin         // first word of any row
                     nxt_s.st     = nst_pkg::NST_OPW;
                     nxt_s.op_cnt = 15'(`NST_SWP_OP - 1);
                  end
                  `NST_CMD_SECT: begin
                     nxt_s.st     = nst_pkg::NST_OPW;
                     nxt_s.op_cnt = 15'(ERA_OP - 1);
                  end
                  `NST_CMD_MASS: begin
                     nxt_s.st     = nst_pkg::NST_OPW;
                     nxt_s.op_cnt = 15'(MASS_OP - 1);
                  end
                  `NST_CMD_BLANK: begin
                     nxt_s.st      = nst_pkg::NST_SETUP;
                     nxt_s.bus_cnt = 5'(`NST_BLK_SETUP - 1);
                  end
                  default: begin               // unknown code is dropped
                     nxt_s.err = 1'b1;
                  end
               endcase
            end
         end
         nst_pkg::NST_OPW: begin
            if (op_tick) begin
               if (s_ff.op_cnt == '0) begin
                  if (s_ff.cmd == `NST_CMD_PROG) begin         // bus part follows
                     nxt_s.st      = nst_pkg::NST_BUSW;
                     nxt_s.bus_cnt = s_ff.burst ? 5'(`NST_BWP_BUS - 1)
                                                : 5'(`NST_SWP_BUS - 1);
                  end else begin               // erase finished
                     nxt_s.st      = nst_pkg::NST_IDLE;
                     nxt_s.done    = 1'b1;
                     nxt_s.pe_inc  = 1'b1;
                     nxt_s.pe_mass = s_ff.cmd == `NST_CMD_MASS;
                  end
               end else begin
                  nxt_s.op_cnt = s_ff.op_cnt - 15'h0001;
               end
            end
         end
         nst_pkg::NST_BUSW: begin
            if (s_ff.bus_cnt == '0) begin      // word programmed
               nxt_s.done = 1'b1;
               if (chain) begin                // pipelined next word
                  pop           = 1'b1;
                  div_clr       = 1'b1;
                  nxt_s.st      = nst_pkg::NST_OPW;
                  nxt_s.burst   = 1'b1;
                  nxt_s.row_cnt = s_ff.row_cnt + 6'h01;
                  nxt_s.op_cnt  = 15'(`NST_BWP_OP - 1);
               end else begin
                  nxt_s.st    = nst_pkg::NST_IDLE;
                  nxt_s.burst = 1'b0;
               end
            end else begin
               nxt_s.bus_cnt = s_ff.bus_cnt - 5'h01;
            end
         end
         nst_pkg::NST_SETUP: begin
            if (s_ff.bus_cnt == '0) begin
               nxt_s.st = nst_pkg::NST_SCAN;
            end else begin
               nxt_s.bus_cnt = s_ff.bus_cnt - 5'h01;
            end
         end
         nst_pkg::NST_SCAN: begin              // one word per bus cycle
            if (!WORD_BLANK_I) begin           // first data word ends it
               nxt_s.st   = nst_pkg::NST_IDLE;
               nxt_s.fail = 1'b1;
               nxt_s.done = 1'b1;
            end else if (s_ff.addr == last_word(s_ff.arr)) begin
               nxt_s.st   = nst_pkg::NST_IDLE;
               nxt_s.fail = 1'b0;
               nxt_s.done = 1'b1;
            end else begin
               nxt_s.addr = s_ff.addr + 16'h0001;
            end
         end
         default: begin                        // illegal code recovers
            nxt_s.st = nst_pkg::NST_IDLE;
         end
      endcase
      // one-deep command queue keeps the pipeline filled
      if (pop) begin
         nxt_s.q_valid = 1'b0;
      end
      if (CMD_VALID_I && s_ff.ready) begin
         nxt_s.q_valid = 1'b1;
         nxt_s.q_cmd   = CMD_CODE_I;
         nxt_s.q_arr   = CMD_ARRAY_I;
      end
      nxt_s.ready = !nxt_s.q_valid;
      nxt_s.busy  = nxt_s.st != nst_pkg::NST_IDLE;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         s_ff       <= '0;
         s_ff.st    <= nst_pkg::NST_IDLE;
         s_ff.ready <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign CMD_READY_O  = s_ff.ready;
   assign BUSY_O       = s_ff.busy;
   assign DONE_O       = s_ff.done;
   assign CMD_ERR_O    = s_ff.err;
   assign BLANK_FAIL_O = s_ff.fail;
   assign SCAN_ADDR_O  = s_ff.addr;
   assign SCAN_ARRAY_O = s_ff.arr;
   assign BURST_O      = s_ff.burst;
   assign PE_INC_O     = s_ff.pe_inc;
   assign PE_MASS_O    = s_ff.pe_mass;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   sequence s_setup;
      (s_ff.st == nst_pkg::NST_SETUP)[*8] ##1 (s_ff.st == nst_pkg::NST_SETUP)[*2];
   endsequence

   sequence s_enter_bus;
      $changed(s_ff.st) && s_ff.st == nst_pkg::NST_BUSW;
   endsequence

   chk_row_limit: assert property (s_ff.row_cnt <= 6'(`NST_ROW_WORDS - 1))
      else $error("row burst ran past its word limit");
   chk_burst_bus_len: assert property (s_enter_bus |-> s_ff.bus_cnt ==
         (s_ff.burst ? 5'(`NST_BWP_BUS - 1) : 5'(`NST_SWP_BUS - 1)))
      else $error("program bus phase loaded with wrong length");
   chk_erase_load: assert property ($changed(s_ff.st) && s_ff.st == nst_pkg::NST_OPW
         && s_ff.cmd != `NST_CMD_PROG |-> s_ff.op_cnt ==
         (s_ff.cmd == `NST_CMD_MASS ? 15'(MASS_OP - 1) : 15'(ERA_OP - 1)))
      else $error("erase loaded with wrong length");
   chk_setup_len: assert property ($rose(s_ff.st == nst_pkg::NST_SETUP) |->
         s_setup ##1 s_ff.st == nst_pkg::NST_SCAN)
      else $error("blank check setup not ten cycles");
   chk_scan_stop: assert property (s_ff.st == nst_pkg::NST_SCAN && !WORD_BLANK_I |=>
         s_ff.st == nst_pkg::NST_IDLE && s_ff.done && s_ff.fail)
      else $error("blank check did not stop at data");
   chk_scan_range: assert property (s_ff.st == nst_pkg::NST_SCAN |->
         s_ff.addr <= last_word(s_ff.arr))
      else $error("blank check address beyond block");
   chk_eeprom_words: assert property (s_ff.burst |-> !s_ff.arr)
      else $error("burst word on eeprom");
   chk_erase_cycle: assert property (s_ff.pe_inc |-> s_ff.done
         && (s_ff.cmd == `NST_CMD_SECT || s_ff.cmd == `NST_CMD_MASS))
      else $error("cycle count pulse without erase completion");
   chk_done_pulse: assert property (s_ff.done |=> !s_ff.done || s_ff.cmd == `NST_CMD_PROG)
      else $error("completion flag held");

endmodule

// >>> rtl/nst_regs.svh
// timing counts and limits of the flash/eeprom command sequencer
`ifndef NST_REGS_SVH
`define NST_REGS_SVH

// ---------------------------------------------------------------
// programming times
// ---------------------------------------------------------------
`define NST_SWP_OP      9      // single word: operation-clock periods
`define NST_SWP_BUS     25     // single word: bus-clock periods
`define NST_BWP_OP      4      // consecutive burst word: operation-clock periods
`define NST_BWP_BUS     9      // consecutive burst word: bus-clock periods
`define NST_ROW_WORDS   64     // words in one flash row burst

// ---------------------------------------------------------------
// erase times
// ---------------------------------------------------------------
`define NST_ERA_OP      4000   // sector erase: operation-clock periods
`define NST_MASS_OP     20000  // mass erase: operation-clock periods

// ---------------------------------------------------------------
// blank check
// ---------------------------------------------------------------
`define NST_BLK_SETUP   10     // command setup in bus cycles
`define NST_FL_WORDS    65536  // words in the flash block
`define NST_EE_WORDS    2048   // words in the eeprom block

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define NST_CMD_PROG    3'h1
`define NST_CMD_SECT    3'h2
`define NST_CMD_MASS    3'h3
`define NST_CMD_BLANK   3'h4

`endif

// >>> rtl/nst_pkg.sv
// types of the flash/eeprom command sequencer
package nst_pkg;

   // ------------------------------------------------------------
   // sequencer states, gray along idle-op-bus-setup-scan
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      NST_IDLE  = 3'h0,   // waiting for a queued command
      NST_OPW   = 3'h1,   // counting operation-clock periods
      NST_BUSW  = 3'h3,   // counting bus-clock periods
      NST_SETUP = 3'h2,   // blank check command setup
      NST_SCAN  = 3'h6    // blank check word scan
   } nst_state_t;

   // ------------------------------------------------------------
   // operation-clock divider state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cnt;    // oscillator ticks seen
      logic       tick;   // operation-clock enable
   } nst_div_t;

   // ------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------
   typedef struct packed {
      nst_state_t  st;        // current phase
      logic [2:0]  cmd;       // running command
      logic        arr;       // running array, 1 = eeprom
      logic        q_valid;   // queue slot filled
      logic [2:0]  q_cmd;     // queued command
      logic        q_arr;     // queued array
      logic [14:0] op_cnt;    // operation periods left minus one
      logic [4:0]  bus_cnt;   // bus periods left minus one
      logic [15:0] addr;      // blank check word address
      logic [5:0]  row_cnt;   // words done in this row burst
      logic        burst;     // current word is a consecutive one
      logic        ready;     // queue slot free
      logic        busy;      // an operation runs
      logic        done;      // completion pulse
      logic        err;       // illegal command pulse
      logic        fail;      // last blank check found data
      logic        pe_inc;    // program/erase cycle pulse
      logic        pe_mass;   // cycle was a mass erase
   } nst_seq_t;

endpackage

// >>> rtl/nst_op_clk_div.sv
// operation-clock enable divider fed by oscillator ticks
`timescale 1ns/1ns
module nst_op_clk_div #(
   parameter int DIV_W = 8                  // divider value width
) (
   input  wire logic             clk_i,      // bus clock
   input  wire logic             rst_i,      // async reset, high
   input  wire logic             clr_i,      // restart the period
   input  wire logic             osc_tick_i, // one oscillator period
   input  wire logic [DIV_W-1:0] div_i,      // period is div_i+1 ticks
   output logic                  tick_o      // operation-clock enable
);

   nst_pkg::nst_div_t div_ff;               // registered state
   nst_pkg::nst_div_t nxt_div;              // next state

   // ------------------------------------------------------------
   // count oscillator ticks, pulse at the period end
   // ------------------------------------------------------------
   always_comb begin
      nxt_div      = div_ff;
      nxt_div.tick = 1'b0;
      if (clr_i) begin                      // fresh period for new command
         nxt_div.cnt = '0;
      end else if (osc_tick_i) begin
         if (div_ff.cnt >= div_i[7:0]) begin  // period complete
            nxt_div.cnt  = '0;
            nxt_div.tick = 1'b1;
         end else begin
            nxt_div.cnt = div_ff.cnt + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   assign tick_o = div_ff.tick;

endmodule

// >>> sim/nst_arr_model.sv
// array and oscillator stand-in on the far side of the sequencer
`timescale 1ns/1ns
module nst_arr_model (
   input  wire logic        clk_i,      // bus clock
   input  wire logic        rst_i,      // async reset, high
   input  wire logic [15:0] addr_i,     // word under blank check
   input  wire logic        arr_i,      // 1 = eeprom
   input  wire logic [15:0] fl_first_i, // first flash word holding data
   input  wire logic [15:0] ee_first_i, // first eeprom word holding data
   output logic             osc_tick_o, // one pulse per oscillator period
   output logic             blank_o     // word at addr_i is erased
);
   // ---------------------------------------------------------------
   // oscillator: one tick every second bus cycle, well inside range
   // ---------------------------------------------------------------
   always @(negedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_tick_o <= 1'b0;
      end else begin
         osc_tick_o <= ~osc_tick_o;
      end
   end

   // words below the first dirty one read as erased
   assign blank_o = arr_i ? (addr_i < ee_first_i) : (addr_i < fl_first_i);
endmodule

// >>> sim/tb_top.sv
// self-checking bench of the flash/eeprom command sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_mismatch++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   // ---------------------------------------------------------------
   // shortened counts and bench state
   // ---------------------------------------------------------------
   localparam int ERA = 20, MASS = 50, FLW = 64, EEW = 32;
   typedef struct {logic pe; logic mass; logic fail; logic bst; logic arr; int lo; int hi;} nst_note_t;
   nst_note_t   notes[$];                 // expected completions
   nst_note_t   nt;                       // note being compared
   logic        clk, rst, osc, valid, arr, blank, ready, busy, done, err;
   logic        bfail, sarr, burst, pe_inc, pe_mass, burst_q, last_fail;
   logic [2:0]  code;                     // command code driven
   logic [7:0]  fdiv, ediv;               // per-array dividers
   logic [15:0] saddr, fl_first, ee_first;
   int          n_mismatch, samples_checked, t, errs, errs_exp;

   nst_sequencer #(.ERA_OP(ERA), .MASS_OP(MASS), .FL_WORDS(FLW), .EE_WORDS(EEW)) u_dut (
      .CLK_SYS_I(clk), .RST_I(rst), .OSC_TICK_I(osc), .FLASH_CLK_DIV_I(fdiv),
      .EEPROM_CLK_DIV_I(ediv), .CMD_VALID_I(valid), .CMD_CODE_I(code), .CMD_ARRAY_I(arr),
      .WORD_BLANK_I(blank), .CMD_READY_O(ready), .BUSY_O(busy), .DONE_O(done), .CMD_ERR_O(err),
      .BLANK_FAIL_O(bfail), .SCAN_ADDR_O(saddr), .SCAN_ARRAY_O(sarr), .BURST_O(burst),
      .PE_INC_O(pe_inc), .PE_MASS_O(pe_mass));
   nst_arr_model u_arr (.clk_i(clk), .rst_i(rst), .addr_i(saddr), .arr_i(sarr), .fl_first_i(fl_first),
      .ee_first_i(ee_first), .osc_tick_o(osc), .blank_o(blank));

   // ---------------------------------------------------------------
   // clock: 4 ns bus period, well above the minimum bus rate
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // operation period in bus cycles: divider+1 ticks, tick every 2 cycles
   function automatic int per(logic a);
      return a ? (int'(ediv) + 1) * 2 : (int'(fdiv) + 1) * 2;
   endfunction

   // offer one command, hold it until the edge that takes it
   task automatic send(logic [2:0] c, logic a);
      @(negedge clk);
      valid = 1'b1;
      code  = c;
      arr   = a;
      while (ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      valid = 1'b0;
   endtask

   // note the expected completion, then issue the command
   task automatic cmd(logic [2:0] c, logic a, logic bst);
      int p, lm;
      nst_note_t n;
      p = per(a);
      n = '{1'b0, 1'b0, last_fail, bst, a, 0, 0};
      case (c)
         3'h1: begin
            n.lo = bst ? 4 * p + 8 : 9 * p + 24;
            n.hi = bst ? 5 * p + 13 : 10 * p + 29;
         end
         3'h2: n = '{1'b1, 1'b0, last_fail, 1'b0, a, ERA * p - 1, (ERA + 1) * p + 4};
         3'h3: n = '{1'b1, 1'b1, last_fail, 1'b0, a, MASS * p - 1, (MASS + 1) * p + 4};
         3'h4: begin
            lm = a ? ((ee_first < EEW) ? int'(ee_first) : EEW) : ((fl_first < FLW) ? int'(fl_first) : FLW);
            last_fail = a ? (ee_first < EEW) : (fl_first < FLW);
            n = '{1'b0, 1'b0, last_fail, 1'b0, a, lm + 10, lm + 14};
         end
         default: errs_exp++;
      endcase
      if (c >= 3'h1 && c <= 3'h4) notes.push_back(n);
      send(c, a);
   endtask

   task automatic wait_idle;
      int k;
      k = 0;
      while ((busy !== 1'b0 || ready !== 1'b1 || notes.size() != 0) && k < 20000) begin
         @(negedge clk);
         k++;
      end
      // a hang here is a failure, not a silent pass
      if (k >= 20000) begin
         n_mismatch++;
         $display("unexpected idle_timeout expected 0 seen 1");
      end
      repeat (2) @(negedge clk);
   endtask

   // ---------------------------------------------------------------
   // monitor: time each operation, compare at its completion pulse
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      if (rst) begin
         t = 0;
      end else begin
         if (busy === 1'b1) t++;
         if (err === 1'b1) errs++;
         if (done === 1'b1) begin
            if (notes.size() == 0) begin
               `CHK("spurious_done", 1'b0, 1'b1)
            end else begin
               nt = notes.pop_front();
               `CHK("pe_inc", nt.pe, pe_inc)
               if (nt.pe) `CHK("pe_mass", nt.mass, pe_mass)
               `CHK("blank_fail", nt.fail, bfail)
               `CHK("burst", nt.bst, burst_q)
               `CHK("array", nt.arr, sarr)
               `CHK("duration_in_window", 1'b1, t >= nt.lo && t <= nt.hi)
            end
            t = 0;
         end
      end
      burst_q = burst;
   end

   // ---------------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      $display("unexpected timeout expected 0 seen 1");
      wrap_up();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1; valid = 1'b0; code = 3'h0; arr = 1'b0; fdiv = 8'h00; ediv = 8'h00;
      fl_first = 16'h0000; ee_first = 16'h0000; last_fail = 1'b0;
      n_mismatch = 0; samples_checked = 0; errs = 0; errs_exp = 0;
      void'($urandom(32'hABBCEC3C));
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      `CHK("ready_after_reset", 1'b1, ready)
      `CHK("busy_after_reset", 1'b0, busy)
      // every command on both arrays, random dividers and dirty words
      for (int r = 0; r < 4; r++) begin
         fdiv = 8'($urandom % 4);
         ediv = 8'($urandom % 4);
         fl_first = 16'($urandom % (FLW + 1));
         ee_first = 16'($urandom % (EEW + 1));
         for (int a = 0; a < 2; a++) begin
            for (int c = 1; c < 5; c++) begin
               cmd(3'(c), 1'(a), 1'b0);
               wait_idle();
            end
         end
      end
      // blank check bounds: first word dirty, whole blocks erased
      fl_first = 16'h0000;
      cmd(3'h4, 1'b0, 1'b0);
      wait_idle();
      fl_first = 16'(FLW);
      cmd(3'h4, 1'b0, 1'b0);
      wait_idle();
      ee_first = 16'(EEW);
      cmd(3'h4, 1'b1, 1'b0);
      wait_idle();
      // illegal codes are dropped with an error pulse
      for (int i = 0; i < 4; i++) cmd(3'((i == 0) ? 0 : i + 4), 1'($urandom % 2), 1'b0);
      wait_idle();
      // full flash row kept queued, then one word past it
      fdiv = 8'h01;
      for (int k = 0; k < 65; k++) cmd(3'h1, 1'b0, k > 0 && k < 64);
      wait_idle();
      // eeprom words queued back to back never chain
      for (int k = 0; k < 4; k++) cmd(3'h1, 1'b1, 1'b0);
      wait_idle();
      // erase with a blank check queued behind it
      cmd(3'h2, 1'b1, 1'b0);
      cmd(3'h4, 1'b0, 1'b0);
      wait_idle();
      // reset in the middle of a mass erase
      cmd(3'h3, 1'b0, 1'b0);
      repeat (30) @(negedge clk);
      rst = 1'b1;
      notes.delete();
      last_fail = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK("busy_after_abort", 1'b0, busy)
      `CHK("ready_after_abort", 1'b1, ready)
      cmd(3'h2, 1'b0, 1'b0);
      wait_idle();
      `CHK("err_pulses", errs_exp, errs)
      wrap_up();
   end
endmodule
